// ===== hw/mfsc_pkg.sv
// Constants and carrier types for the motor fault and speed command block.
// Assumes a 125 MHz core clock and measurement codes produced on that clock.
package mfsc_pkg;

   // Clock rate and derived timing.
   localparam int unsigned CLK_KHZ = 125000;
   localparam int unsigned LOCK_OFF_MS = 1000;
   localparam int unsigned SPD_SAMPLE_US = 1;
   localparam int unsigned SPD_SAMPLE_DIV = (SPD_SAMPLE_US * CLK_KHZ) / 1000;
   localparam int unsigned SPD_WINDOW = 512;

   // Serial port address; the value is arbitrary.
   localparam logic [6:0] I2C_ADDR = 7'h52;

   // Register offsets.
   localparam logic [7:0] REG_FAULT = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h01;
   localparam logic [7:0] REG_IPHASE = 8'h10;
   localparam logic [7:0] REG_VSUPPLY = 8'h11;
   localparam logic [7:0] REG_SPEED = 8'h30;
   localparam logic [7:0] REG_NV_BASE = 8'h90;
   localparam int unsigned NV_REGS = 7;

   // Field positions.
   localparam int unsigned FLT_TSD_BIT = 15;
   localparam int unsigned FLT_WARN_BIT = 14;
   localparam int unsigned FLT_OC_BIT = 11;
   localparam int unsigned STS_UV_BIT = 0;
   localparam int unsigned STS_OV_BIT = 1;
   localparam int unsigned STS_LOCK_LSB = 2;
   localparam int unsigned SPD_OVR_BIT = 15;
   localparam int unsigned CFG_MIN_LSB = 0;
   localparam int unsigned CFG_SRC_BIT = 2;

   // Reset values.
   localparam logic [15:0] SPEED_RST = 16'h0000;
   localparam logic [15:0] NV_RST = 16'h0000;

   // Threshold codes on the 10-bit measurement scale.
   localparam logic [9:0] TSDN_CODE = 10'h300;
   localparam logic [9:0] TSDN_HYS_CODE = 10'h040;
   localparam logic [9:0] TWARN_CODE = 10'h2A0;
   localparam logic [9:0] UV_FALL_CODE = 10'h080;
   localparam logic [9:0] UV_RISE_CODE = 10'h0A0;
   localparam logic [9:0] OV_RISE_CODE = 10'h380;
   localparam logic [9:0] OV_FALL_CODE = 10'h350;
   localparam logic [9:0] TRIP_LEVEL_CODE = 10'h3C0;

   // Minimum pulse-width duty floor.
   localparam logic [8:0] MIN_DUTY = 9'h033;
   localparam logic [8:0] MIN_DUTY_HI = 9'h066;

   // Phase spacing and amplitude scale.
   localparam logic [7:0] PHASE_STEP = 8'h55;
   localparam logic [5:0] AMP_GAIN = 6'h25;

   typedef struct packed {
      logic [9:0] temp;
      logic temp_valid;
      logic [9:0] vsupply;
      logic vsupply_valid;
      logic [9:0] iphase;
      logic iphase_valid;
   } mfsc_meas_t;

   typedef struct packed {
      logic [8:0] surge_guard;
      logic [8:0] accel_limit;
      logic [8:0] loop_limit;
   } mfsc_limit_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ACK = 3'b010,
      ST_RX = 3'b011,
      ST_TX = 3'b100,
      ST_TXACK = 3'b101
   } mfsc_i2c_st_t;

endpackage

// ===== hw/mfsc_sync.sv
// Two flip-flop synchroniser for pin inputs.
// Assumes the inputs are asynchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module mfsc_sync #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_q <= RST_VAL;
         q_out <= RST_VAL;
      end else begin
         meta_q <= d_in;
         q_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ===== hw/mfsc_timer.sv
// One-shot down counter that stays busy for CYC cycles after a start.
// Assumes start is a one-cycle pulse on the core clock.
`timescale 1ns/1ps
`default_nettype none
module mfsc_timer #(
   parameter int unsigned CYC = 1
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic start_in,
   output logic busy_out
);
   logic [31:0] cnt_q;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= 32'h0;
      end else if (start_in) begin
         cnt_q <= 32'(CYC);
      end else if (cnt_q != 32'h0) begin
         cnt_q <= cnt_q - 32'h1;
      end
   end

   assign busy_out = (cnt_q != 32'h0);
endmodule
`default_nettype wire

// ===== hw/mfsc_top.sv
// Fault supervision, speed command selection and phase modulation.
// Assumes measurement codes, limits, lock flags and angle come from core-clock logic.
`timescale 1ns/1ps
`default_nettype none
module mfsc_top #(
   parameter int unsigned LOCK_OFF_CYC = mfsc_pkg::LOCK_OFF_MS * mfsc_pkg::CLK_KHZ
) (
   // Clock and reset.
   input wire logic CORE_CLK_IN,
   input wire logic RST_N_IN,
   // Serial register port.
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE_OUT,
   // Command pins.
   input wire logic SPEED_PIN_IN,
   input wire logic DIR_IN,
   // Analog front end and estimator.
   input wire logic [9:0] SPEED_ADC_IN,
   input wire mfsc_pkg::mfsc_meas_t MEAS_IN,
   input wire mfsc_pkg::mfsc_limit_t LIMIT_IN,
   input wire logic [2:0] LOCK_DET_IN,
   input wire logic COMM_STEP_IN,
   input wire logic [7:0] ANGLE_IN,
   // Nonvolatile store.
   input wire logic WAKE_IN,
   input wire logic [6:0][15:0] NV_DATA_IN,
   // Drive outputs.
   output logic [2:0][8:0] PHASE_DUTY_OUT,
   output logic PHASE_EN_OUT,
   output logic [8:0] PEAK_DUTY_OUT,
   output logic TACH_OUT
);
   import mfsc_pkg::*;

   logic scl_s, sda_s, spd_s, dir_s;
   logic scl_d_q, sda_d_q;
   logic tsd_q, warn_q, uv_q, ov_q, oc_flag_q;
   logic [2:0] lock_src_q;
   logic [9:0] iph_q, vsup_q;
   logic [15:0] speed_q;
   logic [6:0][15:0] nv_q;
   logic boot_q;
   logic oc_busy, lock_busy, oc_start, lock_start;
   logic drive;
   logic [7:0] div_q;
   logic [8:0] win_q, hi_cnt_q, pwm_duty_q;
   logic [8:0] pwm_cmd, cmd, peak;
   logic [1:0] min_sel;
   mfsc_i2c_st_t st_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q, tx_q, ptr_q, hi_q, wr_addr_q;
   logic [1:0] idx_q;
   logic rw_q, rd_lo_q, wr_stb_q, rd_stb_q;
   logic [15:0] wr_data_q;
   logic [7:0] rd_addr_q;
   logic scl_rise, scl_fall, i2c_start, i2c_stop;
   logic [15:0] rd_word;
   logic [7:0] rd_byte;
   logic [2:0][9:0] sn;
   logic [9:0] mn;
   logic [2:0][8:0] duty;

   mfsc_sync #(.W(2), .RST_VAL(2'b11)) u_sync_bus (
      .clk_in(CORE_CLK_IN),
      .rst_n_in(RST_N_IN),
      .d_in({SCL_IN, SDA_IN}),
      .q_out({scl_s, sda_s})
   );

   mfsc_sync #(.W(2), .RST_VAL(2'b00)) u_sync_pins (
      .clk_in(CORE_CLK_IN),
      .rst_n_in(RST_N_IN),
      .d_in({SPEED_PIN_IN, DIR_IN}),
      .q_out({spd_s, dir_s})
   );

   // Temperature supervision with shutdown hysteresis and warning.
   always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         tsd_q <= 1'b0;
         warn_q <= 1'b0;
      end else if (MEAS_IN.temp_valid) begin
         if (MEAS_IN.temp > TSDN_CODE) begin
            tsd_q <= 1'b1;
         end else if (MEAS_IN.temp < TSDN_CODE - TSDN_HYS_CODE) begin
            tsd_q <= 1'b0;
         end
         warn_q <= (MEAS_IN.temp > TWARN_CODE);
      end
   end

   // Supply supervision for lockout and overvoltage.
   always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         uv_q <= 1'b1;
         ov_q <= 1'b0;
      end else if (MEAS_IN.vsupply_valid) begin
         if (MEAS_IN.vsupply < UV_FALL_CODE) begin
            uv_q <= 1'b1;
         end else if (MEAS_IN.vsupply > UV_RISE_CODE) begin
            uv_q <= 1'b0;
         end
         if (MEAS_IN.vsupply > OV_RISE_CODE) begin
            ov_q <= 1'b1;
         end else if (MEAS_IN.vsupply < OV_FALL_CODE) begin
            ov_q <= 1'b0;
         end
      end
   end

   // Readings held for the register port.
   always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         iph_q <= 10'h000;
         vsup_q <= 10'h000;
      end else begin
         if (MEAS_IN.iphase_valid) begin
            iph_q <= MEAS_IN.iphase;
         end
         if (MEAS_IN.vsupply_valid) begin
            vsup_q <= MEAS_IN.vsupply;
         end
      end
   end

   // Overcurrent and lock protection timers.
   assign oc_start = MEAS_IN.iphase_valid && (MEAS_IN.iphase > TRIP_LEVEL_CODE) && !oc_busy;
   assign lock_start = drive && PHASE_EN_OUT && (LOCK_DET_IN != 3'b000) && !lock_busy;

   mfsc_timer #(.CYC(LOCK_OFF_CYC)) u_oc_timer (
      .clk_in(CORE_CLK_IN),
      .rst_n_in(RST_N_IN),
      .start_in(oc_start),
      .busy_out(oc_busy)
   );

   mfsc_timer #(.CYC(LOCK_OFF_CYC)) u_lock_timer (
      .clk_in(CORE_CLK_IN),
      .rst_n_in(RST_N_IN),
      .start_in(lock_start),
      .busy_out(lock_busy)
   );

   // Overcurrent flag clears on a read of the fault word; a new trip wins.
   always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         oc_flag_q <= 1'b0;
      end else if (oc_start) begin
         oc_flag_q <= 1'b1;
      end else if (rd_stb_q && rd_addr_q == REG_FAULT) begin
         oc_flag_q <= 1'b0;
      end
   end

   // Lock method is held while the lock persists or its release time runs.
   always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         lock_src_q <= 3'b000;
      end else if (lock_start) begin
         lock_src_q <= LOCK_DET_IN;
      end else if (!lock_busy && LOCK_DET_IN == 3'b000) begin
         lock_src_q <= 3'b000;
      end
   end

   // Parameter registers: loaded from the store, overridden by serial writes.
   always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         boot_q <= 1'b1;
         nv_q <= {NV_REGS{NV_RST}};
      end else begin
         boot_q <= 1'b0;
         if (boot_q || WAKE_IN) begin
            nv_q <= NV_DATA_IN;
         end else if (wr_stb_q && wr_addr_q >= REG_NV_BASE
                      && wr_addr_q < REG_NV_BASE + 8'(NV_REGS)) begin
            nv_q[3'(wr_addr_q - REG_NV_BASE)] <= wr_data_q;
         end
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         speed_q <= SPEED_RST;
      end else if (wr_stb_q && wr_addr_q == REG_SPEED) begin
         speed_q <= wr_data_q;
      end
   end

   // Pulse-width speed input: high samples counted over a fixed window.
   always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         div_q <= 8'h00;
         win_q <= 9'h000;
         hi_cnt_q <= 9'h000;
         pwm_duty_q <= 9'h000;
      end else if (div_q == 8'(SPD_SAMPLE_DIV - 1)) begin
         div_q <= 8'h00;
         win_q <= win_q + 9'h001;
         if (win_q == 9'(SPD_WINDOW - 1)) begin
            pwm_duty_q <= (&hi_cnt_q) ? 9'h1FF : hi_cnt_q + {8'h00, spd_s};
            hi_cnt_q <= 9'h000;
         end else begin
            hi_cnt_q <= hi_cnt_q + {8'h00, spd_s};
         end
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   // Minimum duty behaviour and source selection.
   assign min_sel = nv_q[0][CFG_MIN_LSB +: 2];

   always_comb begin
      case (min_sel)
         2'b01: pwm_cmd = (pwm_duty_q < MIN_DUTY) ? MIN_DUTY : pwm_duty_q;
         2'b10: pwm_cmd = (pwm_duty_q < MIN_DUTY) ? 9'h000 : pwm_duty_q;
         2'b11: pwm_cmd = (pwm_duty_q < MIN_DUTY_HI) ? MIN_DUTY_HI : pwm_duty_q;
         default: pwm_cmd = pwm_duty_q;
      endcase
      if (speed_q[SPD_OVR_BIT]) begin
         cmd = speed_q[8:0];
      end else if (nv_q[0][CFG_SRC_BIT]) begin
         cmd = pwm_cmd;
      end else begin
         cmd = SPEED_ADC_IN[9:1];
      end
      peak = cmd;
      if (LIMIT_IN.surge_guard < peak) begin
         peak = LIMIT_IN.surge_guard;
      end
      if (LIMIT_IN.accel_limit < peak) begin
         peak = LIMIT_IN.accel_limit;
      end
      if (LIMIT_IN.loop_limit < peak) begin
         peak = LIMIT_IN.loop_limit;
      end
   end

   assign drive = !tsd_q && !uv_q && !ov_q && !oc_busy && !lock_busy;

   // Quarter-wave sine lookup, offset to centre on 0x100.
   function automatic logic [9:0] sine(input logic [7:0] a);
      logic [3:0] i;
      logic [7:0] m;
      i = a[6] ? ~a[5:2] : a[5:2];
      case (i)
         4'h0: m = 8'h0C;
         4'h1: m = 8'h25;
         4'h2: m = 8'h3E;
         4'h3: m = 8'h56;
         4'h4: m = 8'h6D;
         4'h5: m = 8'h83;
         4'h6: m = 8'h98;
         4'h7: m = 8'hAB;
         4'h8: m = 8'hBD;
         4'h9: m = 8'hCD;
         4'hA: m = 8'hDB;
         4'hB: m = 8'hE6;
         4'hC: m = 8'hF0;
         4'hD: m = 8'hF7;
         4'hE: m = 8'hFC;
         default: m = 8'hFF;
      endcase
      sine = a[7] ? (10'h100 - {2'b00, m}) : (10'h100 + {2'b00, m});
   endfunction

   // Phase waveforms with the lowest phase shifted to ground.
   always_comb begin
      logic [15:0] g;
      logic [17:0] p;
      logic [8:0] v;
      g = 16'h0000;
      p = 18'h00000;
      v = 9'h000;
      sn[0] = sine(ANGLE_IN);
      if (dir_s) begin
         sn[1] = sine(ANGLE_IN + PHASE_STEP);
         sn[2] = sine(ANGLE_IN - PHASE_STEP);
      end else begin
         sn[1] = sine(ANGLE_IN - PHASE_STEP);
         sn[2] = sine(ANGLE_IN + PHASE_STEP);
      end
      mn = sn[0];
      if (sn[1] < mn) begin
         mn = sn[1];
      end
      if (sn[2] < mn) begin
         mn = sn[2];
      end
      for (int k = 0; k < 3; k++) begin
         v = 9'(sn[k] - mn);
         g = ({7'h00, v} * {10'h000, AMP_GAIN}) >> 5;
         if (g > 16'h01FF) begin
            g = 16'h01FF;
         end
         p = {9'h000, g[8:0]} * {9'h000, peak};
         duty[k] = p[17:9];
      end
   end

   // Drive outputs and tachometer.
   always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         PHASE_DUTY_OUT <= '0;
         PHASE_EN_OUT <= 1'b0;
         PEAK_DUTY_OUT <= 9'h000;
      end else begin
         PEAK_DUTY_OUT <= drive ? peak : 9'h000;
         PHASE_EN_OUT <= drive && (peak != 9'h000) && !lock_start;
         PHASE_DUTY_OUT <= (drive && !lock_start) ? duty : '0;
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         TACH_OUT <= 1'b0;
      end else if (COMM_STEP_IN && PHASE_EN_OUT) begin
         TACH_OUT <= !TACH_OUT;
      end
   end

   // Serial port line events.
   always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         scl_d_q <= 1'b1;
         sda_d_q <= 1'b1;
         SDA_OUT <= 1'b0;
      end else begin
         scl_d_q <= scl_s;
         sda_d_q <= sda_s;
         SDA_OUT <= 1'b0;
      end
   end

   assign scl_rise = scl_s && !scl_d_q;
   assign scl_fall = !scl_s && scl_d_q;
   assign i2c_start = scl_s && scl_d_q && sda_d_q && !sda_s;
   assign i2c_stop = scl_s && scl_d_q && !sda_d_q && sda_s;

   // Register read map.
   always_comb begin
      rd_word = 16'h0000;
      if (ptr_q == REG_FAULT) begin
         rd_word[FLT_TSD_BIT] = tsd_q;
         rd_word[FLT_WARN_BIT] = warn_q;
         rd_word[FLT_OC_BIT] = oc_flag_q;
      end else if (ptr_q == REG_STATUS) begin
         rd_word[STS_UV_BIT] = uv_q;
         rd_word[STS_OV_BIT] = ov_q;
         rd_word[STS_LOCK_LSB +: 3] = lock_src_q;
      end else if (ptr_q == REG_IPHASE) begin
         rd_word = {6'h00, iph_q};
      end else if (ptr_q == REG_VSUPPLY) begin
         rd_word = {6'h00, vsup_q};
      end else if (ptr_q == REG_SPEED) begin
         rd_word = speed_q;
      end else if (ptr_q >= REG_NV_BASE && ptr_q < REG_NV_BASE + 8'(NV_REGS)) begin
         rd_word = nv_q[3'(ptr_q - REG_NV_BASE)];
      end
      rd_byte = rd_lo_q ? rd_word[7:0] : rd_word[15:8];
   end

   // Byte-level serial slave: pointer, then high and low data bytes.
   always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         st_q <= ST_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         ptr_q <= 8'h00;
         hi_q <= 8'h00;
         idx_q <= 2'b00;
         rw_q <= 1'b0;
         rd_lo_q <= 1'b0;
         wr_stb_q <= 1'b0;
         rd_stb_q <= 1'b0;
         wr_addr_q <= 8'h00;
         rd_addr_q <= 8'h00;
         wr_data_q <= 16'h0000;
         SDA_OE_OUT <= 1'b0;
      end else begin
         wr_stb_q <= 1'b0;
         rd_stb_q <= 1'b0;
         if (i2c_start) begin
            st_q <= ST_ADDR;
            cnt_q <= 4'h0;
            idx_q <= 2'b00;
            SDA_OE_OUT <= 1'b0;
         end else if (i2c_stop) begin
            st_q <= ST_IDLE;
            SDA_OE_OUT <= 1'b0;
         end else if (scl_rise) begin
            case (st_q)
               ST_ADDR, ST_RX: begin
                  sh_q <= {sh_q[6:0], sda_s};
                  cnt_q <= cnt_q + 4'h1;
               end
               ST_TX: begin
                  cnt_q <= cnt_q + 4'h1;
               end
               ST_TXACK: begin
                  if (sda_s) begin
                     st_q <= ST_IDLE;
                  end
               end
               default: begin
               end
            endcase
         end else if (scl_fall) begin
            case (st_q)
               ST_ADDR: begin
                  if (cnt_q == 4'h8) begin
                     if (sh_q[7:1] == I2C_ADDR) begin
                        st_q <= ST_ACK;
                        rw_q <= sh_q[0];
                        rd_lo_q <= 1'b0;
                        SDA_OE_OUT <= 1'b1;
                     end else begin
                        st_q <= ST_IDLE;
                     end
                  end
               end
               ST_RX: begin
                  if (cnt_q == 4'h8) begin
                     st_q <= ST_ACK;
                     SDA_OE_OUT <= 1'b1;
                     if (idx_q == 2'b00) begin
                        ptr_q <= sh_q;
                        rd_lo_q <= 1'b0;
                        idx_q <= 2'b01;
                     end else if (idx_q == 2'b01) begin
                        hi_q <= sh_q;
                        idx_q <= 2'b10;
                     end else begin
                        wr_data_q <= {hi_q, sh_q};
                        wr_addr_q <= ptr_q;
                        wr_stb_q <= 1'b1;
                        ptr_q <= ptr_q + 8'h01;
                        idx_q <= 2'b01;
                     end
                  end
               end
               ST_ACK, ST_TXACK: begin
                  cnt_q <= 4'h0;
                  if (rw_q) begin
                     st_q <= ST_TX;
                     tx_q <= rd_byte;
                     SDA_OE_OUT <= !rd_byte[7];
                     rd_lo_q <= !rd_lo_q;
                     if (rd_lo_q) begin
                        rd_stb_q <= 1'b1;
                        rd_addr_q <= ptr_q;
                        ptr_q <= ptr_q + 8'h01;
                     end
                  end else begin
                     st_q <= ST_RX;
                     SDA_OE_OUT <= 1'b0;
                  end
               end
               ST_TX: begin
                  if (cnt_q == 4'h8) begin
                     st_q <= ST_TXACK;
                     SDA_OE_OUT <= 1'b0;
                  end else begin
                     tx_q <= {tx_q[6:0], 1'b0};
                     SDA_OE_OUT <= !tx_q[6];
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/mfsc_i2c_host.sv
// Serial host model that reads and writes the block's registers.
// Assumes a pull-up on the data line and a running core clock.
`timescale 1ns/1ps
`default_nettype none
module mfsc_i2c_host
   import mfsc_pkg::*;
(
   input wire logic clk_in,
   input wire logic sda_oe_in,
   output logic scl_out,
   output wire logic sda_out
);
   logic low_q = 1'b0;
   initial scl_out = 1'b1;
   assign sda_out = !low_q && !sda_oe_in;
   task automatic step(input logic l, input logic s);
      low_q <= l;
      scl_out <= s;
      repeat (12) @(posedge clk_in);
   endtask
   task automatic bit_io(input logic b, output logic r);
      step(!b, 1'b0);
      step(!b, 1'b1);
      r = sda_out;
      step(!b, 1'b0);
   endtask
   task automatic start();
      @(posedge clk_in);
      step(1'b0, scl_out);
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
   endtask
   task automatic stop();
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
   endtask
   task automatic byte_io(input logic [7:0] d, input logic m, output logic [7:0] r,
      output logic a);
      for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
      bit_io(m, a);
   endtask
   task automatic wr16(input logic [6:0] a7, input logic [7:0] p, input logic [15:0] d,
      output logic n);
      logic [7:0] r;
      logic [3:0] k;
      start();
      byte_io({a7, 1'b0}, 1'b1, r, k[3]);
      byte_io(p, 1'b1, r, k[2]);
      byte_io(d[15:8], 1'b1, r, k[1]);
      byte_io(d[7:0], 1'b1, r, k[0]);
      stop();
      n = |k;
   endtask
   task automatic rd16(input logic [7:0] p, output logic [15:0] d, output logic n);
      logic [7:0] r;
      logic [2:0] k;
      logic x;
      start();
      byte_io({I2C_ADDR, 1'b0}, 1'b1, r, k[2]);
      byte_io(p, 1'b1, r, k[1]);
      start();
      byte_io({I2C_ADDR, 1'b1}, 1'b1, r, k[0]);
      byte_io(8'hFF, 1'b0, d[15:8], x);
      byte_io(8'hFF, 1'b1, d[7:0], x);
      stop();
      n = |k;
   endtask
endmodule
`default_nettype wire

// ===== tb/mfsc_top_properties.sv
// Checks on fault stops, modulation and tach of the drive block.
// Assumes a bind to mfsc_top from the bench.
`timescale 1ns/1ps
`default_nettype none
module mfsc_top_properties
   import mfsc_pkg::*;
#(
   parameter int unsigned LOCK_OFF_CYC = 50
) (
   input wire logic CORE_CLK_IN,
   input wire logic RST_N_IN,
   input wire mfsc_pkg::mfsc_meas_t MEAS_IN,
   input wire logic [2:0] LOCK_DET_IN,
   input wire logic COMM_STEP_IN,
   input wire logic [2:0][8:0] PHASE_DUTY_OUT,
   input wire logic [8:0] PEAK_DUTY_OUT,
   input wire logic PHASE_EN_OUT,
   input wire logic TACH_OUT
);
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   sequence off_s;
      ##[1:2] !PHASE_EN_OUT;
   endsequence
   a_heat_stop: assert property (
      MEAS_IN.temp_valid && MEAS_IN.temp > TSDN_CODE |-> off_s) else $error("Hot drive.");
   a_low_supply_stop: assert property (
      MEAS_IN.vsupply_valid && MEAS_IN.vsupply < UV_FALL_CODE |-> off_s) else $error("Low drive.");
   a_high_supply_stop: assert property (
      MEAS_IN.vsupply_valid && MEAS_IN.vsupply > OV_RISE_CODE |-> off_s) else $error("High drive.");
   a_trip_stop: assert property (
      MEAS_IN.iphase_valid && MEAS_IN.iphase > TRIP_LEVEL_CODE |-> off_s) else $error("Trip drive.");
   a_lock_stop: assert property (
      (|LOCK_DET_IN) && PHASE_EN_OUT |-> off_s) else $error("Lock drive.");
   a_off_hold: assert property (
      $fell(PHASE_EN_OUT) |-> !PHASE_EN_OUT [*8]) else $error("Short off time.");
   a_one_grounded: assert property (
      PHASE_EN_OUT |-> PHASE_DUTY_OUT[0] == '0 || PHASE_DUTY_OUT[1] == '0 ||
      PHASE_DUTY_OUT[2] == '0) else $error("No grounded phase.");
   a_tach_still: assert property (
      !$past(COMM_STEP_IN) || !$past(PHASE_EN_OUT) |-> $stable(TACH_OUT)) else $error("Tach moved.");
   a_tach_toggle: assert property (
      $past(COMM_STEP_IN) && $past(PHASE_EN_OUT) |-> TACH_OUT != $past(TACH_OUT))
      else $error("Tach stuck.");
   a_duty_bound: assert property (
      PHASE_DUTY_OUT[0] <= PEAK_DUTY_OUT && PHASE_DUTY_OUT[1] <= PEAK_DUTY_OUT &&
      PHASE_DUTY_OUT[2] <= PEAK_DUTY_OUT) else $error("Duty above peak.");
endmodule
`default_nettype wire

// ===== tb/mfsc_top_tb.sv
// Bench for the fault and speed command block, driven over the serial port.
// Assumes the host model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
$display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module mfsc_top_tb;
   import mfsc_pkg::*;
   localparam int unsigned LCYC = 50;
   logic clk, rst_n, dir, wake, comm, scl, sda, sda_o, sda_oe, en, tach, n;
   logic [9:0] adc;
   logic [7:0] ang;
   logic [2:0] lock;
   logic [6:0][15:0] nv;
   logic [2:0][8:0] duty, d0;
   logic [8:0] peak;
   mfsc_meas_t meas;
   mfsc_limit_t lim;
   int num_errors = 0;
   int checks_done = 0;
   int hi;
   logic [12:0] tbl [10] = '{13'h12A1, 13'h0301, 13'h02C0, 13'h12A0, 13'h047F, 13'h04A0,
      13'h14A1, 13'h0781, 13'h0750, 13'h174F};
   mfsc_top #(.LOCK_OFF_CYC(LCYC)) uut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .SCL_IN(scl),
      .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .SPEED_PIN_IN(1'b0), .DIR_IN(dir),
      .SPEED_ADC_IN(adc), .MEAS_IN(meas), .LIMIT_IN(lim), .LOCK_DET_IN(lock),
      .COMM_STEP_IN(comm), .ANGLE_IN(ang), .WAKE_IN(wake), .NV_DATA_IN(nv),
      .PHASE_DUTY_OUT(duty), .PHASE_EN_OUT(en), .PEAK_DUTY_OUT(peak), .TACH_OUT(tach));
   mfsc_i2c_host host (.clk_in(clk), .sda_oe_in(sda_oe && !sda_o), .scl_out(scl), .sda_out(sda));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      ang <= ang + 8'h01;
      comm <= ang[3:0] == 4'hF;
   end
   task automatic end_of_test();
      if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [7:0] p, input logic [15:0] d);
      host.wr16(I2C_ADDR, p, d, n);
      `CHK(n, 1'b0)
   endtask
   task automatic rd(input logic [7:0] p, input logic [15:0] e);
      logic [15:0] d;
      host.rd16(p, d, n);
      `CHK({n, d}, {1'b0, e})
   endtask
   task automatic smp(input logic [1:0] k, input logic [9:0] c);
      @(posedge clk);
      if (k == 2'h0) meas.temp <= c;
      if (k == 2'h1) meas.vsupply <= c;
      if (k == 2'h2) meas.iphase <= c;
      {meas.temp_valid, meas.vsupply_valid, meas.iphase_valid} <= 3'b100 >> k;
      @(posedge clk);
      {meas.temp_valid, meas.vsupply_valid, meas.iphase_valid} <= 3'b000;
      repeat (6) @(posedge clk);
      #1;
   endtask
   initial begin
      {rst_n, dir, wake, comm, ang, lock, meas} = '0;
      lim = '1;
      adc = 10'h2A6;
      nv = '0;
      nv[6] = 16'h1234;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1 `CHK({en, peak, tach}, 11'h000)
      rd(REG_NV_BASE + 8'h06, 16'h1234);
      rd(8'h20, 16'h0000);
      wr(REG_SPEED, 16'h8100);
      host.wr16(7'h53, REG_SPEED, 16'h80FF, n);
      `CHK(n, 1'b1)
      rd(REG_SPEED, 16'h8100);
      smp(2'h1, 10'h200);
      `CHK({en, peak}, 10'h300)
      smp(2'h2, 10'h123);
      rd(REG_VSUPPLY, 16'h0200);
      rd(REG_IPHASE, 16'h0123);
      @(posedge clk) lim.surge_guard <= 9'h080;
      repeat (4) @(posedge clk);
      #1 `CHK(peak, 9'h080)
      @(posedge clk) lim.surge_guard <= 9'h1FF;
      foreach (tbl[i]) begin
         smp(tbl[i][11:10], tbl[i][9:0]);
         `CHK(en, tbl[i][12])
         if (i == 1) rd(REG_FAULT, 16'hC000);
         if (i == 4) rd(REG_STATUS, 16'h0001);
         if (i == 7) rd(REG_STATUS, 16'h0002);
      end
      smp(2'h2, 10'h3C1);
      `CHK(en, 1'b0)
      smp(2'h2, 10'h100);
      repeat (LCYC) @(posedge clk);
      #1 `CHK(en, 1'b1)
      rd(REG_FAULT, 16'h0800);
      rd(REG_FAULT, 16'h0000);
      @(posedge clk) lock <= 3'b010;
      hi = 0;
      repeat (3 * LCYC) begin
         @(posedge clk);
         #1 hi += en;
      end
      `CHK(hi inside {[2:9]}, 1'b1)
      rd(REG_STATUS, 16'h0008);
      @(posedge clk) lock <= 3'b000;
      repeat (LCYC + 4) @(posedge clk);
      #1 `CHK(en, 1'b1)
      wr(REG_SPEED, 16'h0000);
      repeat (4) @(posedge clk);
      #1 `CHK(peak, 9'h153)
      d0 = duty;
      @(posedge clk) dir <= 1'b1;
      repeat (255) @(posedge clk);
      #1 `CHK(duty, {d0[1], d0[2], d0[0]})
      wr(REG_NV_BASE, 16'h0005);
      repeat (4) @(posedge clk);
      #1 `CHK(peak, MIN_DUTY)
      wr(REG_NV_BASE, 16'h0007);
      repeat (4) @(posedge clk);
      #1 `CHK(peak, MIN_DUTY_HI)
      wr(REG_NV_BASE + 8'h06, 16'hBEEF);
      rd(REG_NV_BASE + 8'h06, 16'hBEEF);
      @(posedge clk) wake <= 1'b1;
      @(posedge clk) wake <= 1'b0;
      rd(REG_NV_BASE + 8'h06, 16'h1234);
      end_of_test();
   end
   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      end_of_test();
   end
endmodule
bind mfsc_top mfsc_top_properties #(.LOCK_OFF_CYC(LOCK_OFF_CYC)) u_props (
   .CORE_CLK_IN(CORE_CLK_IN), .RST_N_IN(RST_N_IN), .MEAS_IN(MEAS_IN),
   .LOCK_DET_IN(LOCK_DET_IN), .COMM_STEP_IN(COMM_STEP_IN), .PHASE_DUTY_OUT(PHASE_DUTY_OUT),
   .PHASE_EN_OUT(PHASE_EN_OUT), .TACH_OUT(TACH_OUT), .PEAK_DUTY_OUT(PEAK_DUTY_OUT));
`default_nettype wire
